/* File: src/fsp_pkg.sv */
`default_nettype none
package fsp_pkg;
  // ==========================================================
  // register map (byte offsets on the bus)
  localparam logic [4:0] OFS_CTRL = 5'h00;  // serial_control
  localparam logic [4:0] OFS_BUF = 5'h04;   // serial_buffer
  localparam logic [4:0] OFS_PWR = 5'h08;   // power_control
  localparam logic [4:0] OFS_SLAVE_ADDR = 5'h0C; // slave_addr
  localparam logic [4:0] OFS_SMASK = 5'h10; // slave_addr_mask
  localparam int PWR_DBL_BIT = 7;           // baud_doubler position
  localparam logic [7:0] REG_RST = 8'h00;   // value of every register after reset
  // ==========================================================
  // modes as chosen by {mode_sel_hi, mode_sel_lo}
  localparam logic [1:0] MODE_SYNC = 2'h0;  // 8-bit shift mode
  localparam logic [1:0] MODE_A10 = 2'h1;   // 10-bit, timer rate
  localparam logic [1:0] MODE_A11F = 2'h2;  // 11-bit, fixed rate
  localparam logic [1:0] MODE_A11T = 2'h3;  // 11-bit, timer rate
  // ==========================================================
  // timing counts: prescaler limits in system clocks, then tick, edge and bit indexes
  localparam logic [2:0] M0_HALF_SLOW = 3'h6; // half of a 12-clock shift period
  localparam logic [2:0] M0_HALF_FAST = 3'h2; // half of a 4-clock shift period
  localparam logic [2:0] M2_TICK_SLOW = 3'h4; // 64 clocks per bit / 16
  localparam logic [2:0] M2_TICK_FAST = 3'h2; // 32 clocks per bit / 16
  localparam logic [3:0] OVS_LAST = 4'hF;     // last state of the divide-by-16
  localparam logic [3:0] SMP_A = 4'h7;        // first vote sample
  localparam logic [3:0] SMP_B = 4'h8;        // second vote sample
  localparam logic [3:0] SMP_C = 4'h9;        // third sample, bit decided
  localparam logic [3:0] M0_LAST = 4'h7;      // index of the eighth shift edge
  localparam logic [3:0] LAST_A10 = 4'h9;     // stop bit index, 10-bit frame
  localparam logic [3:0] LAST_A11 = 4'hA;     // stop bit index, 11-bit frame
  // ==========================================================
  // serial_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic mode_sel_hi;
    logic mode_sel_lo;
    logic multiproc_ctrl;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } fsp_ctrl_t;
endpackage
`default_nettype wire

/* File: src/fsp_baud.sv */
`default_nettype none
module fsp_baud #(
  parameter int DIV_W = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // rate selection
  input wire logic [1:0] mode_i,
  input wire logic baud_doubler_i,
  input wire logic multiproc_ctrl_i,
  input wire logic timer_ovf_i,
  // rate enables
  output logic tick16_o,
  output logic m0_ph_o
);
  import fsp_pkg::*;

  // ==========================================================
  // prescaler
  if (DIV_W < 3) begin : g_chk
    $error("fsp_baud: DIV_W must be at least 3");
  end

  logic [DIV_W-1:0] div;    // counts system clocks within one step
  logic [DIV_W-1:0] lim;    // clocks per step for the current mode
  logic step;               // one-cycle pulse at the last clock of a step

  // mode 0 steps are half shift periods, mode 2 steps are 1/16 bit
  assign lim = (mode_i == MODE_SYNC) ?
    DIV_W'(multiproc_ctrl_i ? M0_HALF_FAST : M0_HALF_SLOW) :
    DIV_W'(baud_doubler_i ? M2_TICK_FAST : M2_TICK_SLOW);
  assign step = (div >= lim - DIV_W'(1));

  // free running, so bit times never align to a buffer write
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div <= '0;
    end else begin
      div <= step ? '0 : div + DIV_W'(1);
    end
  end

  // timer modes take the overflow itself as the 16x sample rate
  assign tick16_o = (mode_i == MODE_A11F) ? step : (mode_i != MODE_SYNC) & timer_ovf_i;
  assign m0_ph_o = (mode_i == MODE_SYNC) & step;
endmodule
`default_nettype wire

/* File: src/fsp_vote.sv */
`default_nettype none
module fsp_vote (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // sampling
  input wire logic tick_i,
  input wire logic clr_i,
  input wire logic rxd_i,
  // decided bit
  output logic bit_stb_o,
  output logic bit_o
);
  import fsp_pkg::*;

  // ==========================================================
  // bit detector
  logic [3:0] phase;   // sixteenths of the current bit time
  logic smp_a;         // sample at state 7
  logic smp_b;         // sample at state 8

  // a falling edge restarts the count so states line up with bits
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase <= '0;
      smp_a <= 1'b1;
      smp_b <= 1'b1;
      bit_stb_o <= 1'b0;
      bit_o <= 1'b1;
    end else begin
      bit_stb_o <= 1'b0;
      if (clr_i) begin
        phase <= '0;
      end else if (tick_i) begin
        phase <= phase + 4'h1;
        if (phase == SMP_A) smp_a <= rxd_i;
        if (phase == SMP_B) smp_b <= rxd_i;
        if (phase == SMP_C) begin
          // two of three wins, for noise rejection
          bit_o <= (smp_a & smp_b) | (smp_a & rxd_i) | (smp_b & rxd_i);
          bit_stb_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/fsp_top.sv */
// The Avalon-MM register port and the address map were left to the implementer.
`default_nettype none
module fsp_top #(
  parameter int AW = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register bus
  input wire logic [AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // timer overflow for the timer-rate modes
  input wire logic timer_ovf_i,
  // serial pins
  input wire logic serial_in_pin_i,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe_o,
  output logic serial_out_pin_o
);
  import fsp_pkg::*;

  if (AW < 5) begin : g_chk
    $error("fsp_top: AW must be at least 5");
  end

  // bit-reverses a byte gathered by left shifts
  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r[i] = d[7-i];
    return r;
  endfunction

  // given address or broadcast address hit
  function automatic logic addr_hit(input logic [7:0] d, input logic [7:0] a, input logic [7:0] m);
    logic given;
    logic bcast;
    given = (((d ^ a) & m) == 8'h00);
    bcast = ((~d & (a | m)) == 8'h00);
    return given | bcast;
  endfunction

  // ==========================================================
  // registers
  fsp_ctrl_t ctrl;          // serial_control
  logic [7:0] rx_buf;       // serial_buffer as read back
  logic baud_doubler;       // power_control bit
  logic [7:0] slave_addr;   // own address
  logic [7:0] slave_addr_mask; // address care bits

  // ==========================================================
  // bus decode
  logic req;
  logic acc_wr;
  logic hit;
  logic [7:0] rd_mux;
  logic wr_ctrl;
  logic buf_wr;
  assign req = avs_read_i | avs_write_i;
  // a write lands only at the edge where waitrequest is seen low
  assign acc_wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  assign hit = ((avs_address_i >> 5) == '0);
  assign wr_ctrl = acc_wr & hit & (avs_address_i[4:0] == OFS_CTRL);
  assign buf_wr = acc_wr & hit & (avs_address_i[4:0] == OFS_BUF);
  // unmapped offsets read as zero
  assign rd_mux = !hit ? 8'h00 :
    (avs_address_i[4:0] == OFS_CTRL) ? ctrl :
    (avs_address_i[4:0] == OFS_BUF) ? rx_buf :
    (avs_address_i[4:0] == OFS_PWR) ? {baud_doubler, 7'h00} :
    (avs_address_i[4:0] == OFS_SLAVE_ADDR) ? slave_addr :
    (avs_address_i[4:0] == OFS_SMASK) ? slave_addr_mask : 8'h00;

  // one wait cycle per access, so read data are ready at the release
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      if (req & avs_waitrequest_o) avs_readdata_o <= {24'h00_0000, rd_mux};
    end
  end

  // plain configuration registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      baud_doubler <= 1'b0;
      slave_addr <= REG_RST;
      slave_addr_mask <= REG_RST;
    end else if (acc_wr & hit) begin
      if (avs_address_i[4:0] == OFS_PWR) baud_doubler <= avs_writedata_i[PWR_DBL_BIT];
      if (avs_address_i[4:0] == OFS_SLAVE_ADDR) slave_addr <= avs_writedata_i[7:0];
      if (avs_address_i[4:0] == OFS_SMASK) slave_addr_mask <= avs_writedata_i[7:0];
    end
  end

  // ==========================================================
  // mode and rate
  logic [1:0] mode;
  logic m0;
  logic m11;
  logic [3:0] last_idx;
  logic tick16;
  logic m0_ph;
  assign mode = {ctrl.mode_sel_hi, ctrl.mode_sel_lo};
  assign m0 = (mode == MODE_SYNC);
  assign m11 = mode[1];
  assign last_idx = m11 ? LAST_A11 : LAST_A10;

  // mode 0 half periods, mode 2 fixed rate, or the timer overflow
  fsp_baud u_baud (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .mode_i(mode),
    .baud_doubler_i(baud_doubler),
    .multiproc_ctrl_i(ctrl.multiproc_ctrl),
    .timer_ovf_i(timer_ovf_i),
    .tick16_o(tick16),
    .m0_ph_o(m0_ph)
  );

  // ==========================================================
  // state
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT, TX_SYNC} fsp_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_SYNC} fsp_rx_t;
  fsp_tx_t tx_st;
  fsp_rx_t rx_st;

  // ==========================================================
  // mode 0 shift clock, shared by send and receive
  logic sclk;          // shift clock level, idles high
  logic [3:0] m0_cnt;  // rising edges so far
  logic m0_busy;
  logic m0_fall;
  logic m0_rise;
  logic m0_last;
  assign m0_busy = (tx_st == TX_SYNC) | (rx_st == RX_SYNC);
  assign m0_fall = m0_ph & sclk & m0_busy;
  assign m0_rise = m0_ph & ~sclk & m0_busy;
  assign m0_last = m0_rise & (m0_cnt == M0_LAST);

  // the device makes the clock whichever way data flows
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk <= 1'b1;
      m0_cnt <= '0;
    end else if (!m0_busy) begin
      sclk <= 1'b1;
      m0_cnt <= '0;
    end else if (m0_ph) begin
      sclk <= ~sclk;
      if (!sclk) m0_cnt <= m0_cnt + 4'h1;
    end
  end

  // ==========================================================
  // transmitter
  logic [10:0] tx_sr;  // frame, bit 0 on the line
  logic [3:0] tx_cnt;  // bits already sent in this frame
  logic [3:0] tx16;    // transmit divide-by-16
  logic tx_roll;
  logic tx_set;
  assign tx_roll = tick16 & (tx16 == OVS_LAST);
  // stop bit goes out now, or the eighth shift edge has passed
  assign tx_set = ((tx_st == TX_SHIFT) & tx_roll & (tx_cnt == last_idx - 4'h1)) |
    ((tx_st == TX_SYNC) & m0_last);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx16 <= '0;
    end else if (tick16) begin
      tx16 <= tx16 + 4'h1;
    end
  end

  // a write restarts the sender even mid-frame; software should wait for the flag
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_st <= TX_IDLE;
      tx_sr <= '1;
      tx_cnt <= '0;
    end else if (buf_wr) begin
      tx_st <= TX_WAIT;
      tx_cnt <= '0;
      // async: stop, ninth or second stop, data, start
      tx_sr <= m0 ? {3'b000, avs_writedata_i[7:0]} :
        {1'b1, m11 ? ctrl.tx_ninth_bit : 1'b1, avs_writedata_i[7:0], 1'b0};
    end else begin
      case (tx_st)
        TX_WAIT: begin
          // mode 0 waits while a shift-in owns the clock
          if (m0 & (rx_st != RX_SYNC)) tx_st <= TX_SYNC;
          else if (!m0 & tx_roll) tx_st <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tx_roll) begin
            tx_sr <= {1'b1, tx_sr[10:1]};
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == last_idx) tx_st <= TX_IDLE;
          end
        end
        TX_SYNC: begin
          // the first falling edge comes before bit 0 is taken
          if (m0_fall & (m0_cnt != 4'h0)) tx_sr <= {1'b0, tx_sr[10:1]};
          if (m0_last) tx_st <= TX_IDLE;
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // receiver
  logic [8:0] rx_sr;    // ninth bit and data, filled from the top
  logic [3:0] rx_idx;   // index of the next bit in the frame
  logic rxd_prev;       // line at the previous 16x sample
  logic rx_arm;
  logic rx_fall;
  logic rx_clr;
  logic bit_stb;
  logic bit_val;
  logic frame_end;
  logic [8:0] rx_cand;
  logic rx_ok;
  logic rx_load;
  logic [7:0] m0_byte;
  assign rx_arm = ctrl.rx_enable & ~ctrl.rx_done_flag;
  assign rx_fall = tick16 & rxd_prev & ~serial_in_pin_i;
  assign rx_clr = (rx_st == RX_IDLE) & !m0 & rx_arm & rx_fall;
  assign frame_end = (rx_st == RX_BITS) & bit_stb & (rx_idx == last_idx);
  // 10-bit frames keep the stop bit as the ninth bit
  assign rx_cand = m11 ? rx_sr : {bit_val, rx_sr[8:1]};
  assign rx_ok = ~ctrl.rx_done_flag & (~ctrl.multiproc_ctrl |
    (m11 ? rx_cand[8] & addr_hit(rx_cand[7:0], slave_addr, slave_addr_mask) : bit_val));
  assign m0_byte = rev8({rx_sr[6:0], serial_in_pin_i});
  assign rx_load = (frame_end & rx_ok) | ((rx_st == RX_SYNC) & m0_last);

  fsp_vote u_vote (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick16),
    .clr_i(rx_clr),
    .rxd_i(serial_in_pin_i),
    .bit_stb_o(bit_stb),
    .bit_o(bit_val)
  );

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rxd_prev <= 1'b1;
    end else if (tick16) begin
      rxd_prev <= serial_in_pin_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_st <= RX_IDLE;
      rx_sr <= '0;
      rx_idx <= '0;
    end else begin
      case (rx_st)
        RX_IDLE: begin
          // mode 0 receive needs the clock free of a send
          if (m0 & rx_arm & (tx_st == TX_IDLE)) rx_st <= RX_SYNC;
          else if (rx_clr) rx_st <= RX_BITS;
          rx_idx <= '0;
        end
        RX_BITS: begin
          if (bit_stb) begin
            rx_idx <= rx_idx + 4'h1;
            if ((rx_idx == 4'h0) & bit_val) rx_st <= RX_IDLE;
            if (rx_idx == last_idx) rx_st <= RX_IDLE;
            // start bit and an 11-bit frame's stop bit are not kept
            if ((rx_idx != 4'h0) & !(m11 & (rx_idx == last_idx))) rx_sr <= {bit_val, rx_sr[8:1]};
          end
        end
        RX_SYNC: begin
          if (m0_rise) rx_sr[7:0] <= {rx_sr[6:0], serial_in_pin_i};
          if (m0_last) rx_st <= RX_IDLE;
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // serial_control and received byte; hardware set beats software clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl <= REG_RST;
      rx_buf <= REG_RST;
    end else begin
      if (wr_ctrl) ctrl <= avs_writedata_i[7:0];
      if (tx_set) ctrl.tx_done_flag <= 1'b1;
      if (rx_load) begin
        ctrl.rx_done_flag <= 1'b1;
        rx_buf <= m0 ? m0_byte : rx_cand[7:0];
        if (!m0) ctrl.rx_ninth_bit <= rx_cand[8];
      end
    end
  end

  // ==========================================================
  // pins, all from flip-flops
  logic next_out;
  assign next_out = m0_busy ? sclk : (tx_st == TX_SHIFT) & !m0 ? tx_sr[0] : 1'b1;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      serial_out_pin_o <= 1'b1;
      serial_in_pin_o <= 1'b1;
      serial_in_pin_oe_o <= 1'b0;
    end else begin
      serial_out_pin_o <= next_out;
      serial_in_pin_o <= tx_sr[0];
      // keep driving one clock past the last rising clock on the pin, so the peer's latch has hold time
      serial_in_pin_oe_o <= (tx_st == TX_SYNC) | (serial_in_pin_oe_o & ~serial_out_pin_o);
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_line_idle_high: assert property ((tx_st == TX_IDLE) && !m0_busy && !m0 |=> serial_out_pin_o)
    else $error("async line not high while idle");
  a_write_starts_tx: assert property (buf_wr |=> tx_st == TX_WAIT)
    else $error("buffer write did not start a send");
  a_rx_held_off: assert property ((rx_st == RX_IDLE) && ctrl.rx_done_flag |=> rx_st == RX_IDLE)
    else $error("reception started with flag set");
  a_m0_slow_clock: assert property ((m0_ph && m0 && !ctrl.multiproc_ctrl) ##1
    (m0 && !ctrl.multiproc_ctrl) [*5] |-> !m0_ph && !$past(m0_ph, 1) && !$past(m0_ph, 2)
    && !$past(m0_ph, 3) && !$past(m0_ph, 4))
    else $error("mode 0 clock faster than 1/12");
  a_bad_start_abort: assert property ((rx_st == RX_BITS) && bit_stb && rx_idx == 4'h0 && bit_val
    |=> rx_st == RX_IDLE)
    else $error("bad start bit not aborted");
  a_load_sets_flag: assert property (rx_load |=> ctrl.rx_done_flag
    && rx_buf == ($past(m0) ? $past(m0_byte) : $past(rx_cand[7:0])))
    else $error("load did not set flag or buffer");
  a_buf_hold: assert property (ctrl.rx_done_flag |=> $stable(rx_buf))
    else $error("buffer overwritten while flag set");
  a_m0_send_len: assert property (buf_wr && m0 && ctrl.multiproc_ctrl && !ctrl.tx_done_flag
    && rx_st == RX_IDLE |-> ##[28:40] ctrl.tx_done_flag)
    else $error("mode 0 send length wrong");
  c_async_rx: cover property (frame_end && rx_ok);
  c_m0_send: cover property ((tx_st == TX_SYNC) && m0_last);
  c_m0_recv: cover property ((rx_st == RX_SYNC) && m0_last);
endmodule
`default_nettype wire

/* File: tb/fsp_peer.sv */
`default_nettype none
module fsp_peer (
  // clock
  input wire logic clk_i,
  // device shift clock in mode 0
  input wire logic sclk_i,
  // line toward the device
  output var logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // mode 0 shift source
  logic m0_on = 1'b0; // mode 0 source active
  logic [7:0] m0_sh = 8'h00; // bits still to present
  logic sclk_q = 1'b1; // last shift clock level
  initial line_o = 1'b1; // idle line is high
  // move on only after a rising edge, so the device has latched
  always @(posedge clk_i) begin
    sclk_q <= sclk_i;
    if (m0_on && sclk_i && !sclk_q) begin
      m0_sh <= {1'b1, m0_sh[7:1]}; // ones fill so the line ends idle
      line_o <= m0_sh[1];
    end
  end
  // present a byte for a mode 0 reception, lsb first
  task automatic load0(input logic [7:0] b);
    m0_on <= 1'b1;
    m0_sh <= b;
    line_o <= b[0];
  endtask
  // async frame, bits[0] first, each held per clocks
  task automatic send(input logic [10:0] bits, input int nb, input int per);
    m0_on <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      line_o <= bits[i];
      repeat (per) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: tb/fsp_top_tb.sv */
`default_nettype none
module fsp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fsp_pkg::*;
  // ==========
  // stimulus, responses and bookkeeping
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic timer_ovf_i = 1'b0; // 16x tick, one pulse every two clocks
  logic pin_o, pin_oe, sclk_o, peer_line, line;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  // device wins the data line while it drives it
  assign line = pin_oe ? pin_o : peer_line;
  fsp_top u_fsp_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h1),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .timer_ovf_i(timer_ovf_i),
    .serial_in_pin_i(line), .serial_in_pin_o(pin_o), .serial_in_pin_oe_o(pin_oe), .serial_out_pin_o(sclk_o));
  fsp_peer u_fsp_peer (.clk_i(clk_i), .sclk_i(sclk_o), .line_o(peer_line));
  initial forever #20 clk_i = ~clk_i;
  // cycle count, timer ticks and hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    timer_ovf_i <= ~timer_ovf_i;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // ==========
  // shared tasks
  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h00_0000, d};
    avs_read_i <= rd;
    avs_write_i <= !rd;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, output logic [7:0] q);
    acc(1'b1, a, 8'h00, q);
  endtask
  // wait for a rising shift clock, bounded
  task automatic rise();
    int n;
    n = 0;
    while (sclk_o !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    while (sclk_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) miscompares++;
  endtask
  // sample an async frame in the middle of each bit
  task automatic cap(input int nb, input int per, output logic [10:0] v);
    int n;
    n = 0;
    v = 11'h000;
    while (sclk_o !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) miscompares++;
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      v[i] = sclk_o;
      repeat (per) @(posedge clk_i);
    end
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    logic [7:0] q;
    for (int a = 0; a < 5; a++) begin
      rdc(5'(a * 4), q);
      chk("reset value", {3'h0, q}, {3'h0, REG_RST});
    end
    wr(5'h14, 8'hFF); // unmapped place
    rdc(5'h14, q);
    chk("unmapped", {3'h0, q}, 11'h000);
  endtask
  // mode 0 send at both rates: clock period, lsb first on the data line
  task automatic t_m0_tx();
    logic [7:0] q;
    logic [7:0] b;
    int t0;
    b = 8'h96;
    for (int mp = 0; mp < 2; mp++) begin
      wr(OFS_CTRL, mp ? 8'h20 : 8'h00);
      wr(OFS_BUF, 8'h96);
      for (int i = 0; i < 8; i++) begin
        rise();
        if (i == 0) t0 = cyc;
        if (i == 1) chk("shift period", 11'(cyc - t0), 11'(2 * (mp ? M0_HALF_FAST : M0_HALF_SLOW)));
        chk("m0 data", {9'h000, pin_oe, pin_o}, {9'h000, 1'b1, b[i]});
      end
      repeat (30) @(posedge clk_i);
      rdc(OFS_CTRL, q);
      chk("m0 tx done", {10'h000, q[1]}, 11'h001);
    end
  endtask
  // mode 0 receive, then the clock stays quiet while the flag is set
  task automatic t_m0_rx();
    logic [7:0] q;
    int n;
    u_fsp_peer.load0(8'h3C);
    wr(OFS_CTRL, 8'h10);
    repeat (160) @(posedge clk_i);
    rdc(OFS_BUF, q);
    chk("m0 rx data", {3'h0, q}, 11'h03C);
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (sclk_o !== 1'b1) n++;
    end
    chk("m0 rx held", 11'(n), 11'h000);
    wr(OFS_CTRL, 8'h00);
  endtask
  // mode 2 send at both fixed rates, ninth bit from the control bit
  task automatic t_m2_tx();
    logic [7:0] q;
    logic [10:0] v;
    for (int k = 0; k < 2; k++) begin
      wr(OFS_PWR, k ? 8'h80 : 8'h00);
      wr(OFS_CTRL, k ? 8'h88 : 8'h80);
      chk("idle high", {10'h000, sclk_o}, 11'h001);
      wr(OFS_BUF, k ? 8'h5A : 8'hC3);
      cap(11, k ? 32 : 64, v);
      chk("m2 frame", v, {1'b1, k[0], k ? 8'h5A : 8'hC3, 1'b0});
      rdc(OFS_CTRL, q);
      chk("m2 tx done", {10'h000, q[1]}, 11'h001);
    end
  endtask
  // mode 1 receive, flag gating, stop rule, then a send
  task automatic t_m1();
    logic [7:0] q;
    logic [10:0] v;
    wr(OFS_CTRL, 8'h50);
    u_fsp_peer.send({1'b1, 8'hE7, 1'b0}, 10, 32);
    repeat (20) @(posedge clk_i);
    rdc(OFS_CTRL, q);
    chk("m1 rx flags", {8'h00, q[2:0]}, 11'h005);
    u_fsp_peer.send({1'b1, 8'h11, 1'b0}, 10, 32);
    repeat (20) @(posedge clk_i);
    rdc(OFS_BUF, q);
    chk("m1 rx kept", {3'h0, q}, 11'h0E7);
    wr(OFS_CTRL, 8'h70);
    u_fsp_peer.send({1'b0, 8'h33, 1'b0}, 10, 32);
    repeat (20) @(posedge clk_i);
    rdc(OFS_CTRL, q);
    chk("m1 bad stop", {10'h000, q[0]}, 11'h000);
    wr(OFS_CTRL, 8'h40);
    wr(OFS_BUF, 8'h81);
    cap(10, 32, v);
    chk("m1 frame", v, {2'b01, 8'h81, 1'b0});
    rdc(OFS_CTRL, q);
    chk("m1 tx done", {10'h000, q[1]}, 11'h001);
  endtask
  // short low pulse is dropped, the next frame still lands
  task automatic t_bad_start();
    logic [7:0] q;
    wr(OFS_CTRL, 8'h50);
    u_fsp_peer.send(11'h002, 2, 6);
    repeat (60) @(posedge clk_i);
    u_fsp_peer.send({1'b1, 8'h6B, 1'b0}, 10, 32);
    repeat (20) @(posedge clk_i);
    rdc(OFS_BUF, q);
    chk("after glitch", {3'h0, q}, 11'h06B);
  endtask
  // mode 3 address filter: given, data byte, mismatch, broadcast
  task automatic t_m3_addr();
    logic [7:0] q;
    logic [9:0] fr [4] = '{10'h3A0, 10'h0A0, 10'h1A2, 10'h3FE}; // {load, ninth, byte}
    wr(OFS_SLAVE_ADDR, 8'hA4);
    wr(OFS_SMASK, 8'hFA);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, 8'hF0);
      u_fsp_peer.send({1'b1, fr[i][8:0], 1'b0}, 11, 32);
      repeat (20) @(posedge clk_i);
      rdc(OFS_CTRL, q);
      chk("addr filter", {10'h000, q[0]}, {10'h000, fr[i][9]});
    end
    rdc(OFS_BUF, q);
    chk("broadcast data", {3'h0, q}, 11'h0FE);
  endtask
  // ==========
  // verdict
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_m0_tx();
    t_m0_rx();
    t_m2_tx();
    t_m1();
    t_bad_start();
    t_m3_addr();
    stop_test();
  end
endmodule
`default_nettype wire
